/* dv/asx_remote.sv */
// Remote serial party on the line pins
`timescale 1ns/1ps
module asx_remote #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  // Mark level when idle, as a pulled-up line sits
  initial line_out = 1'h1;
  // ==========================================
  // Frame driver and capture
  task automatic send(input logic [8:0] w, input int n, input logic stp);
    @(negedge mclk) line_out = 1'h0;
    repeat (BIT_CYC) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      line_out = w[i];
      repeat (BIT_CYC) @(negedge mclk);
    end
    line_out = stp;
    repeat (BIT_CYC) @(negedge mclk);
    line_out = 1'h1;
    repeat (BIT_CYC) @(negedge mclk);
  endtask
  // Samples mid-bit; stop bits are not captured
  task automatic recv(input int n, output logic [8:0] w);
    w = 9'h000;
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      w[i] = line_in;
    end
  endtask
endmodule

/* dv/asx_transceiver_assertions.sv */
// Port-level assertions for the serial transceiver
`timescale 1ns/1ps
module asx_chk
  import asx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire asx_cfg_t cfg,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic tx_write_valid,
  input wire logic [TXW-1:0] tx_write_data,
  input wire logic tx_queue_flush,
  input wire logic rx_queue_flush,
  input wire logic rx_read_valid,
  input wire logic rx_read_ready,
  input wire logic [RXW-1:0] rx_read_data,
  input wire asx_stat_t status
);
  // ==========================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence start_low;
    !serial_out_pin [*8];
  endsequence
  chk_start_len:
  assert property ($fell(serial_out_pin) && cfg.baud_divisor == 16'h0001
    |-> start_low ##1 start_low) else $error("start bit shorter than 16 ticks");
  chk_idle_mark:
  assert property (status.tx_shifter_idle [*3] |-> serial_out_pin)
    else $error("line low while shifter idle");
  chk_gate_freeze:
  assert property (!cfg.baud_tick_gate && !$past(cfg.baud_tick_gate) |-> $stable(serial_out_pin))
    else $error("line moved with ticks gated off");
  chk_full_not_low:
  assert property (status.tx_queue_full |-> !status.tx_queue_low)
    else $error("tx full and low together");
  chk_valid_has_data:
  assert property (rx_read_valid |-> status.rx_queue_has_data)
    else $error("read valid with empty queue");
  chk_half_queue:
  assert property (status.rx_queue_above_half |-> cfg.queue_mode_enable && rx_read_valid)
    else $error("above half without queuing");
  chk_rx_flush:
  assert property (rx_queue_flush |=> !rx_read_valid && status[4:0] == 5'h00)
    else $error("rx flush left data or flags");
  chk_read_hold:
  assert property (rx_read_valid && !rx_read_ready && !rx_queue_flush
    |=> rx_read_valid && $stable(rx_read_data)) else $error("read word changed unread");
endmodule

bind asx_transceiver asx_chk chk_inst (.mclk(mclk), .rst(rst), .cfg(cfg),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .tx_write_valid(tx_write_valid), .tx_write_data(tx_write_data),
  .tx_queue_flush(tx_queue_flush), .rx_queue_flush(rx_queue_flush),
  .rx_read_valid(rx_read_valid), .rx_read_ready(rx_read_ready),
  .rx_read_data(rx_read_data), .status(status));

/* dv/tb_asx_transceiver.sv */
// Self-checking bench for the asynchronous serial transceiver
`timescale 1ns/1ps
module tb_asx_transceiver;
  import asx_pkg::*;
  typedef struct {
    logic [2:0] fmt;
    logic odd;
    logic [8:0] tx;
    logic [8:0] bits;
    int n;
    logic [9:0] rx;
  } asx_row_t;
  // Word written, bits on the line, word read back
  asx_row_t rows[7] = '{
    '{3'h1, 1'h0, 9'h0A5, 9'h0A5, 8, 10'h0A5},
    '{3'h3, 1'h0, 9'h015, 9'h095, 8, 10'h015},
    '{3'h3, 1'h1, 9'h015, 9'h015, 8, 10'h015},
    '{3'h4, 1'h0, 9'h1A5, 9'h1A5, 9, 10'h1A5},
    '{3'h7, 1'h0, 9'h003, 9'h003, 9, 10'h003},
    '{3'h7, 1'h1, 9'h003, 9'h103, 9, 10'h003},
    '{3'h5, 1'h0, 9'h1C3, 9'h1C3, 9, 10'h1C3}};
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic twv = 1'h0, tqf = 1'h0, rqf = 1'h0, rrr = 1'h0;
  logic sin, sout, rrv;
  logic [8:0] twd = 9'h000;
  logic [8:0] got;
  logic [9:0] rrd;
  asx_cfg_t cfg = '0;
  asx_stat_t st;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  asx_transceiver asx_transceiver_inst (.mclk(mclk), .rst(rst), .cfg(cfg),
    .serial_in_pin(sin), .serial_out_pin(sout), .tx_write_valid(twv), .tx_write_data(twd),
    .tx_queue_flush(tqf), .rx_queue_flush(rqf), .rx_read_valid(rrv), .rx_read_ready(rrr),
    .rx_read_data(rrd), .status(st));
  asx_remote remote_inst (.mclk(mclk), .line_in(sout), .line_out(sin));
  initial forever #25 mclk = ~mclk;
  // ==========================================
  // Helpers
  task automatic ck(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [8:0] d);
    @(negedge mclk) twd = d;
    twv = 1'h1;
    @(negedge mclk) twv = 1'h0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'h1;
    @(negedge mclk) s = 1'h0;
  endtask
  task automatic rd(input logic [9:0] e);
    int k;
    k = 0;
    while (rrv !== 1'h1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    ck(rrd, e);
    @(negedge mclk) rrr = 1'h1;
    @(negedge mclk) rrr = 1'h0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 6000 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test;
    end
  end
  // ==========================================
  // Sequence
  initial begin
    cfg.baud_divisor = 16'h0001;
    cfg.stop_bits_select = STOP_ONE;
    cfg.queue_mode_enable = 1'h1;
    cfg.receiver_on = 1'h1;
    cfg.baud_tick_gate = 1'h1;
    repeat (16) @(negedge mclk);
    rst = 1'h0;
    ck({1'h0, st, sout}, 10'h0C1); // RESET
    foreach (rows[i]) begin
      cfg.frame_format_field = rows[i].fmt;
      cfg.odd_check_select = rows[i].odd;
      fork
        remote_inst.recv(rows[i].n, got);
        wr(rows[i].tx);
        remote_inst.send(rows[i].bits, rows[i].n, 1'h1);
      join
      ck({1'h0, got}, {1'h0, rows[i].bits});
      rd(rows[i].rx);
    end
    cfg.frame_format_field = FMT_8DP;
    cfg.odd_check_select = 1'h0;
    remote_inst.send(9'h103, 9, 1'h1);
    ck({2'h0, st}, 10'h071);
    rd(10'h103);
    remote_inst.send(9'h0A5, 9, 1'h0);
    ck({2'h0, st}, 10'h072);
    rd(10'h2A5);
    for (int s = 0; s < 4; s++) begin
      cfg.stop_bits_select = 2'(s);
      remote_inst.send(9'h0A5, 9, 1'h1);
      rd(10'h0A5);
    end
    cfg.frame_format_field = FMT_8DW;
    remote_inst.send(9'h0C3, 9, 1'h1);
    ck({2'h0, st}, 10'h060);
    fork
      remote_inst.send(9'h1C3, 9, 1'h1);
      #2000 cfg.receiver_on = 1'h0;
    join
    rd(10'h1C3);
    remote_inst.send(9'h1C3, 9, 1'h1);
    ck({2'h0, st}, 10'h060);
    cfg.receiver_on = 1'h1;
    cfg.queue_mode_enable = 1'h0;
    pulse(tqf);
    pulse(rqf);
    repeat (2) remote_inst.send(9'h1C3, 9, 1'h1);
    ck({2'h0, st}, 10'h074);
    rd(10'h1C3);
    ck({2'h0, st}, 10'h060);
    cfg.queue_mode_enable = 1'h1;
    pulse(tqf);
    cfg.baud_tick_gate = 1'h0;
    for (int k = 0; k < 18; k++) wr(9'(k));
    ck({2'h0, st}, 10'h080);
    pulse(tqf);
    ck({2'h0, st}, 10'h040);
    cfg.queue_mode_enable = 1'h0;
    pulse(tqf);
    wr(9'h155);
    wr(9'h1AA);
    ck({2'h0, st}, 10'h080);
    fork
      remote_inst.recv(9, got);
      cfg.baud_tick_gate = 1'h1;
    join
    ck({1'h0, got}, 10'h000);
    remote_inst.recv(9, got);
    ck({1'h0, got}, 10'h1AA);
    repeat (64) @(negedge mclk);
    cfg.internal_echo_select = 1'h1;
    wr(9'h15A);
    rd(10'h15A);
    cfg.internal_echo_select = 1'h0;
    cfg.queue_mode_enable = 1'h1;
    pulse(rqf);
    repeat (8) remote_inst.send(9'h1C3, 9, 1'h1);
    ck({2'h0, st}, 10'h070);
    remote_inst.send(9'h1C3, 9, 1'h1);
    ck({2'h0, st}, 10'h078);
    pulse(rqf);
    ck({2'h0, st}, 10'h060);
    end_of_test;
  end
endmodule

/* verilog/asx_pkg.sv */
// Shared constants and types for the asynchronous serial transceiver
package asx_pkg;

  localparam int QDEPTH = 16;
  localparam int TXW = 9;
  localparam int RXW = 10;

  localparam logic [4:0] Q_HALF = 5'h08;
  localparam logic [4:0] Q_FULL = 5'h10;
  localparam logic [4:0] Q_ONE = 5'h01;

  localparam logic [2:0] FMT_8D = 3'h1;
  localparam logic [2:0] FMT_7DP = 3'h3;
  localparam logic [2:0] FMT_9D = 3'h4;
  localparam logic [2:0] FMT_8DW = 3'h5;
  localparam logic [2:0] FMT_8DP = 3'h7;
  localparam int FMT_NINE_BIT = 2;

  localparam logic [1:0] STOP_HALF = 2'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONEHALF = 2'h2;
  localparam logic [1:0] STOP_TWO = 2'h3;

  // Transmit timing in 16x ticks, counted from zero
  localparam logic [5:0] TX_BIT_LAST = 6'h0F;
  localparam logic [5:0] TX_STOP_HALF_LAST = 6'h07;
  localparam logic [5:0] TX_STOP_ONE_LAST = 6'h0F;
  localparam logic [5:0] TX_STOP_ONEHALF_LAST = 6'h17;
  localparam logic [5:0] TX_STOP_TWO_LAST = 6'h1F;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  // Receive sample numbers, counted from one
  localparam logic [4:0] RX_START_VOTE = 5'h03;
  localparam logic [4:0] RX_DATA_VOTE = 5'h09;
  localparam logic [4:0] RX_BIT_LAST = 5'h10;
  localparam logic [4:0] RX_STOP_HALF_VOTE = 5'h05;
  localparam logic [4:0] RX_STOP_ONE_VOTE = 5'h09;
  localparam logic [4:0] RX_STOP_ONEHALF_VOTE = 5'h11;
  localparam logic [4:0] RX_STOP_SECOND_VOTE = 5'h19;

  typedef struct packed {
    logic [2:0] frame_format_field;
    logic odd_check_select;
    logic [1:0] stop_bits_select;
    logic queue_mode_enable;
    logic internal_echo_select;
    logic receiver_on;
    logic baud_tick_gate;
    logic [15:0] baud_divisor;
  } asx_cfg_t;

  typedef struct packed {
    logic tx_queue_full;
    logic tx_queue_low;
    logic tx_shifter_idle;
    logic rx_queue_has_data;
    logic rx_queue_above_half;
    logic rx_overflow_flag;
    logic stop_bit_fault_flag;
    logic parity_fault_flag;
  } asx_stat_t;

endpackage

/* verilog/asx_queue.sv */
// Sixteen-deep word queue with flush, overwrite of newest and error summary
`timescale 1ns/1ps
module asx_queue
  import asx_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic ovw,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic [4:0] count,
  output logic [W-1:0] any_bits
);

  logic [W-1:0] mem [QDEPTH];
  logic [3:0] wp_reg;
  logic [3:0] rp_reg;
  logic [4:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push && (cnt_reg != Q_FULL);
  assign do_pop = pop && (cnt_reg != 5'h00);
  assign dout = mem[rp_reg];
  assign count = cnt_reg;

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wp_reg] <= din;
    end else if (ovw) begin
      mem[4'(wp_reg - 4'h1)] <= din;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_reg <= 4'h0;
      rp_reg <= 4'h0;
      cnt_reg <= 5'h00;
    end else if (flush) begin
      wp_reg <= 4'h0;
      rp_reg <= 4'h0;
      cnt_reg <= 5'h00;
    end else begin
      if (do_push) wp_reg <= 4'(wp_reg + 4'h1);
      if (do_pop) rp_reg <= 4'(rp_reg + 4'h1);
      cnt_reg <= 5'(cnt_reg + {4'h0, do_push} - {4'h0, do_pop});
    end
  end

  // Only entries between read pointer and count take part in the flags
  always_comb begin
    any_bits = '0;
    for (int i = 0; i < QDEPTH; i++) begin
      if (5'(4'(i - int'(rp_reg))) < cnt_reg) any_bits = any_bits | mem[i];
    end
  end

endmodule

/* verilog/asx_skid.sv */
// Two-entry valid/ready buffer ahead of the receive read port
`timescale 1ns/1ps
module asx_skid #(
  parameter int W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] din,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] dout,
  output logic [1:0] count,
  output logic [W-1:0] any_bits
);

  logic [W-1:0] s0_reg;
  logic [W-1:0] s1_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign dout = s0_reg;
  assign count = cnt_reg;
  assign any_bits = (out_valid ? s0_reg : '0) | ((cnt_reg == 2'h2) ? s1_reg : '0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s0_reg <= '0;
      s1_reg <= '0;
      cnt_reg <= 2'h0;
    end else if (flush) begin
      cnt_reg <= 2'h0;
    end else begin
      if (pop) begin
        s0_reg <= (cnt_reg == 2'h2) ? s1_reg : din;
      end else if (push && cnt_reg == 2'h0) begin
        s0_reg <= din;
      end else if (push) begin
        s1_reg <= din;
      end
      cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule

/* verilog/asx_transceiver.sv */
// Asynchronous serial transceiver: baud ticks, transmit path, receive path
`timescale 1ns/1ps
module asx_transceiver
  import asx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire asx_cfg_t cfg,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic tx_write_valid,
  input wire logic [TXW-1:0] tx_write_data,
  input wire logic tx_queue_flush,
  input wire logic rx_queue_flush,
  output logic rx_read_valid,
  input wire logic rx_read_ready,
  output logic [RXW-1:0] rx_read_data,
  output asx_stat_t status
);

  typedef enum logic [3:0] {
    ASX_TX_IDLE = 4'b0001,
    ASX_TX_START = 4'b0010,
    ASX_TX_DATA = 4'b0100,
    ASX_TX_STOP = 4'b1000
  } asx_tx_state_t;

  typedef enum logic [3:0] {
    ASX_RX_IDLE = 4'b0001,
    ASX_RX_START = 4'b0010,
    ASX_RX_DATA = 4'b0100,
    ASX_RX_STOP = 4'b1000
  } asx_rx_state_t;

  // ==========================================================
  // Baud tick
  // ==========================================================
  logic [15:0] div_cnt_reg;
  logic [15:0] div_last;
  logic tick_reg;

  assign div_last = (cfg.baud_divisor == 16'h0000) ? 16'h0000 :
                    16'(cfg.baud_divisor - 16'h0001);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (!cfg.baud_tick_gate) begin
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= div_last) begin
      div_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= 16'(div_cnt_reg + 16'h0001);
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Frame format decode
  // ==========================================================
  logic nine_bit;
  logic [3:0] last_bit;
  logic [5:0] tx_stop_last;
  logic [4:0] rx_stop_first;
  logic [4:0] rx_stop_last;

  assign nine_bit = cfg.frame_format_field[FMT_NINE_BIT];
  assign last_bit = nine_bit ? LAST_BIT_9 : LAST_BIT_8;

  always_comb begin
    tx_stop_last = TX_STOP_ONE_LAST;
    rx_stop_first = RX_STOP_ONE_VOTE;
    rx_stop_last = RX_STOP_ONE_VOTE;
    unique case (cfg.stop_bits_select)
      STOP_HALF: begin
        tx_stop_last = TX_STOP_HALF_LAST;
        rx_stop_first = RX_STOP_HALF_VOTE;
        rx_stop_last = RX_STOP_HALF_VOTE;
      end
      STOP_ONE: begin
        tx_stop_last = TX_STOP_ONE_LAST;
      end
      STOP_ONEHALF: begin
        tx_stop_last = TX_STOP_ONEHALF_LAST;
        rx_stop_first = RX_STOP_ONEHALF_VOTE;
        rx_stop_last = RX_STOP_ONEHALF_VOTE;
      end
      STOP_TWO: begin
        tx_stop_last = TX_STOP_TWO_LAST;
        rx_stop_last = RX_STOP_SECOND_VOTE;
      end
    endcase
  end

  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] n, input logic odd);
    logic s;
    // Seven-bit format covers only bits 6:0; the parity slot is bit 7
    s = (n == FMT_7DP) ? ^d[6:0] : ^d;
    return s ^ odd;
  endfunction

  // ==========================================================
  // Transmit queue
  // ==========================================================
  logic [TXW-1:0] txq_head;
  logic [4:0] txq_count;
  logic txq_full;
  logic txq_pop;
  logic tx_push;
  logic tx_ovw;

  assign txq_full = cfg.queue_mode_enable ? (txq_count == Q_FULL) :
                                            (txq_count >= Q_ONE);
  assign tx_push = tx_write_valid && !txq_full;
  assign tx_ovw = tx_write_valid && txq_full && !cfg.queue_mode_enable;

  asx_queue #(.W(TXW)) u_txq (
    .mclk(mclk),
    .rst(rst),
    .flush(tx_queue_flush),
    .push(tx_push),
    .ovw(tx_ovw),
    .din(tx_write_data),
    .pop(txq_pop),
    .dout(txq_head),
    .count(txq_count),
    .any_bits()
  );

  // ==========================================================
  // Transmit shifter and sequencer
  // ==========================================================
  asx_tx_state_t tx_state_reg;
  logic [5:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [TXW-1:0] tx_sh_reg;
  logic tx_sh_full_reg;
  logic tx_bit_end;
  logic tx_enter_stop;
  logic tx_idle_load;
  logic [TXW-1:0] tx_frame;
  logic txd_reg;

  assign tx_bit_end = tick_reg && (tx_cnt_reg == TX_BIT_LAST);
  assign tx_enter_stop = tx_bit_end && (tx_state_reg == ASX_TX_DATA) &&
                         (tx_bit_reg == last_bit);
  assign tx_idle_load = !tx_sh_full_reg && (txq_count != 5'h00) &&
                        (tx_state_reg == ASX_TX_IDLE || tx_state_reg == ASX_TX_STOP);
  assign txq_pop = (tx_enter_stop || tx_idle_load) && (txq_count != 5'h00);

  // Parity replaces the top data bit of the frame
  always_comb begin
    tx_frame = txq_head;
    if (cfg.frame_format_field == FMT_7DP) begin
      tx_frame = {1'b0, par_bit(txq_head[7:0], FMT_7DP, cfg.odd_check_select),
                  txq_head[6:0]};
    end else if (cfg.frame_format_field == FMT_8DP) begin
      tx_frame = {par_bit(txq_head[7:0], FMT_8DP, cfg.odd_check_select),
                  txq_head[7:0]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= '0;
      tx_sh_full_reg <= 1'b0;
    end else if (tx_enter_stop && txq_count != 5'h00) begin
      tx_sh_reg <= tx_frame;
    end else if (tx_enter_stop) begin
      tx_sh_full_reg <= 1'b0;
    end else if (tx_idle_load) begin
      tx_sh_reg <= tx_frame;
      tx_sh_full_reg <= 1'b1;
    end else if (tx_bit_end && tx_state_reg == ASX_TX_DATA) begin
      tx_sh_reg <= tx_sh_reg >> 1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= ASX_TX_IDLE;
      tx_cnt_reg <= 6'h00;
      tx_bit_reg <= 4'h0;
    end else if (tick_reg) begin
      unique case (tx_state_reg)
        ASX_TX_IDLE: begin
          if (tx_sh_full_reg) begin
            tx_state_reg <= ASX_TX_START;
            tx_cnt_reg <= 6'h00;
          end
        end
        ASX_TX_START: begin
          if (tx_bit_end) begin
            tx_state_reg <= ASX_TX_DATA;
            tx_cnt_reg <= 6'h00;
            tx_bit_reg <= 4'h0;
          end else begin
            tx_cnt_reg <= 6'(tx_cnt_reg + 6'h01);
          end
        end
        ASX_TX_DATA: begin
          if (tx_enter_stop) begin
            tx_state_reg <= ASX_TX_STOP;
            tx_cnt_reg <= 6'h00;
          end else if (tx_bit_end) begin
            tx_bit_reg <= 4'(tx_bit_reg + 4'h1);
            tx_cnt_reg <= 6'h00;
          end else begin
            tx_cnt_reg <= 6'(tx_cnt_reg + 6'h01);
          end
        end
        ASX_TX_STOP: begin
          if (tx_cnt_reg >= tx_stop_last) begin
            // Back-to-back: next start bit follows the stop period directly
            tx_state_reg <= tx_sh_full_reg ? ASX_TX_START : ASX_TX_IDLE;
            tx_cnt_reg <= 6'h00;
          end else begin
            tx_cnt_reg <= 6'(tx_cnt_reg + 6'h01);
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= (tx_state_reg == ASX_TX_START) ? 1'b0 :
                 (tx_state_reg == ASX_TX_DATA) ? tx_sh_reg[0] : 1'b1;
    end
  end

  assign serial_out_pin = txd_reg;

  // ==========================================================
  // Receive input path
  // ==========================================================
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_line;
  logic rx_prev_reg;
  logic [1:0] vote_reg;
  logic maj;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= serial_in_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  assign rx_line = cfg.internal_echo_select ? txd_reg : rx_s2_reg;
  assign maj = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rx_line) |
               (vote_reg[0] & rx_line);

  // Two previous samples plus the current one feed the vote
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
      vote_reg <= 2'h3;
    end else if (tick_reg) begin
      rx_prev_reg <= rx_line;
      vote_reg <= {vote_reg[0], rx_line};
    end
  end

  // ==========================================================
  // Receive sequencer
  // ==========================================================
  asx_rx_state_t rx_state_reg;
  logic [4:0] samp_reg;
  logic [4:0] samp_n;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;
  logic ferr_reg;
  logic rx_done;
  logic ferr_final;

  assign samp_n = 5'(samp_reg + 5'h01);
  assign rx_done = tick_reg && (rx_state_reg == ASX_RX_STOP) && (samp_n == rx_stop_last);
  assign ferr_final = ferr_reg | !maj;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= ASX_RX_IDLE;
      samp_reg <= 5'h00;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= '0;
      ferr_reg <= 1'b0;
    end else if (tick_reg) begin
      unique case (rx_state_reg)
        ASX_RX_IDLE: begin
          // Receiver enable gates only new starts; a running frame completes
          if (cfg.receiver_on && rx_prev_reg && !rx_line) begin
            rx_state_reg <= ASX_RX_START;
            samp_reg <= 5'h01;
            rx_sh_reg <= '0;
            ferr_reg <= 1'b0;
          end
        end
        ASX_RX_START: begin
          samp_reg <= samp_n;
          if (samp_n == RX_START_VOTE && maj) begin
            rx_state_reg <= ASX_RX_IDLE;
          end else if (samp_n == RX_BIT_LAST) begin
            rx_state_reg <= ASX_RX_DATA;
            samp_reg <= 5'h00;
            rx_bit_reg <= 4'h0;
          end
        end
        ASX_RX_DATA: begin
          samp_reg <= samp_n;
          if (samp_n == RX_DATA_VOTE) begin
            rx_sh_reg[rx_bit_reg] <= maj;
          end
          if (samp_n == RX_BIT_LAST) begin
            samp_reg <= 5'h00;
            rx_bit_reg <= 4'(rx_bit_reg + 4'h1);
            if (rx_bit_reg == last_bit) rx_state_reg <= ASX_RX_STOP;
          end
        end
        ASX_RX_STOP: begin
          samp_reg <= samp_n;
          if (samp_n == rx_stop_first && !maj) ferr_reg <= 1'b1;
          if (rx_done) rx_state_reg <= ASX_RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Receive word build and queueing
  // ==========================================================
  logic [RXW-1:0] rx_word;
  logic rx_accept;
  logic rx_full;
  logic rx_push;
  logic [4:0] rxq_count;
  logic [1:0] skid_count;
  logic [4:0] rx_total;
  logic [RXW-1:0] rxq_head;
  logic [RXW-1:0] rxq_any;
  logic [RXW-1:0] skid_any;
  logic [RXW-1:0] rx_any;
  logic rxq_pop;
  logic skid_ready;
  logic rx_read;
  logic ovf_reg;

  // Parity slot carries the error indication, not the received bit
  always_comb begin
    rx_word = {ferr_final, rx_sh_reg};
    if (cfg.frame_format_field == FMT_7DP) begin
      rx_word[7] = rx_sh_reg[7] ^ par_bit(rx_sh_reg[7:0], FMT_7DP, cfg.odd_check_select);
    end else if (cfg.frame_format_field == FMT_8DP) begin
      rx_word[8] = rx_sh_reg[8] ^ par_bit(rx_sh_reg[7:0], FMT_8DP, cfg.odd_check_select);
    end
  end

  assign rx_accept = (cfg.frame_format_field != FMT_8DW) || rx_sh_reg[8];
  assign rx_total = 5'(rxq_count + {3'h0, skid_count});
  assign rx_full = cfg.queue_mode_enable ? (rx_total >= Q_FULL) : (rx_total >= Q_ONE);
  assign rx_push = rx_done && rx_accept && !rx_full;
  assign rxq_pop = skid_ready && (rxq_count != 5'h00);
  assign rx_read = rx_read_valid && rx_read_ready;

  asx_queue #(.W(RXW)) u_rxq (
    .mclk(mclk),
    .rst(rst),
    .flush(rx_queue_flush),
    .push(rx_push),
    .ovw(1'b0),
    .din(rx_word),
    .pop(rxq_pop),
    .dout(rxq_head),
    .count(rxq_count),
    .any_bits(rxq_any)
  );

  // Oldest words wait here; they count toward the queue limit, so a stalled reader can still overflow
  asx_skid #(.W(RXW)) u_skid (
    .mclk(mclk),
    .rst(rst),
    .flush(rx_queue_flush),
    .in_valid(rxq_count != 5'h00),
    .in_ready(skid_ready),
    .din(rxq_head),
    .out_valid(rx_read_valid),
    .out_ready(rx_read_ready),
    .dout(rx_read_data),
    .count(skid_count),
    .any_bits(skid_any)
  );

  // Overflowing word is dropped; a set in the read cycle wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else if (rx_done && rx_accept && rx_full) begin
      ovf_reg <= 1'b1;
    end else if (rx_read) begin
      ovf_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Status
  // ==========================================================
  assign rx_any = rxq_any | skid_any;

  always_comb begin
    status.tx_queue_full = txq_full;
    status.tx_queue_low = cfg.queue_mode_enable ? (txq_count <= Q_HALF) :
                                                  (txq_count == 5'h00);
    status.tx_shifter_idle = !tx_sh_full_reg;
    status.rx_queue_has_data = (rx_total != 5'h00);
    status.rx_queue_above_half = (rx_total > Q_HALF);
    status.rx_overflow_flag = ovf_reg;
    status.stop_bit_fault_flag = rx_any[9];
    status.parity_fault_flag = (cfg.frame_format_field == FMT_8DP) ? rx_any[8] :
                               (cfg.frame_format_field == FMT_7DP) ? rx_any[7] : 1'b0;
  end

endmodule
